// file: core/sdci_cfg.svh
/*
  Constants for the memory command interface: geometry, mode fields,
  command codes and timing counts. Included by every file of the block.
*/
`ifndef SDCI_CFG_SVH
`define SDCI_CFG_SVH

`define SDCI_BANKS 4
`define SDCI_ROW_BITS 12
`define SDCI_COL_BITS 9
`define SDCI_COL_BITS_X4 11
`define SDCI_DQ_BITS 16
`define SDCI_ADDR_BITS 12
`define SDCI_AP_BIT 10

`define SDCI_CMD_LMR 3'h0
`define SDCI_CMD_REF 3'h1
`define SDCI_CMD_PRE 3'h2
`define SDCI_CMD_ACT 3'h3
`define SDCI_CMD_WR 3'h4
`define SDCI_CMD_RD 3'h5
`define SDCI_CMD_BST 3'h6
`define SDCI_CMD_NOP 3'h7

`define SDCI_BL_MSB 2
`define SDCI_BL_LSB 0
`define SDCI_BL_PAGE 3'h7
`define SDCI_BT_BIT 3
`define SDCI_CL_MSB 6
`define SDCI_CL_LSB 4
`define SDCI_CL_LONG 3'h3
`define SDCI_MODE_RST 12'h020
`define SDCI_HOST_CL 8'h02

`define SDCI_CLK_HZ 20000000
`define SDCI_ROWS 4096
`define SDCI_REF_PERIOD_MS 16
`define SDCI_REF_CYC ((`SDCI_REF_PERIOD_MS * `SDCI_CLK_HZ / 1000) / `SDCI_ROWS)
`define SDCI_GAP_CYC 8'h02
`define SDCI_FIFO_DEPTH 16

`endif

// file: core/sdci_pkg.sv
/*
  Types for both ends: command codes (shared), device power modes, host states.
  Assumes sdci_cfg.svh is on the include path.
*/
`include "sdci_cfg.svh"

package sdci_pkg;
  typedef enum logic [2:0] {
    CMD_LMR = `SDCI_CMD_LMR,
    CMD_REF = `SDCI_CMD_REF,
    CMD_PRE = `SDCI_CMD_PRE,
    CMD_ACT = `SDCI_CMD_ACT,
    CMD_WR = `SDCI_CMD_WR,
    CMD_RD = `SDCI_CMD_RD,
    CMD_BST = `SDCI_CMD_BST,
    CMD_NOP = `SDCI_CMD_NOP
  } sdci_cmd_t;

  typedef enum logic [2:0] {
    PWR_RUN, PWR_PDN_PRE, PWR_PDN_ACT, PWR_SELF_REF, PWR_SUSPEND
  } sdci_pwr_t;

  typedef enum logic [2:0] {
    H_PRE, H_LMR, H_IDLE, H_RW, H_DATA, H_SLEEP
  } sdci_hst_t;
endpackage

// file: core/sdci_if.sv
/*
  Pin bundle between the memory controller and the memory device.
  The data wire is resolved from the device enable alone; device drive wins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdci_cfg.svh"

interface sdci_if #(
  parameter int DQ_BITS = `SDCI_DQ_BITS
);
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic dqm;
  logic [1:0] ba;
  logic [`SDCI_ADDR_BITS-1:0] addr;
  logic [DQ_BITS-1:0] hostDq;
  logic hostDqOe;
  logic [DQ_BITS-1:0] devDq;
  logic devDqOe;
  logic [DQ_BITS-1:0] dq;

  assign dq = devDqOe ? devDq : hostDq;

  modport dev (input cke, csN, rasN, casN, weN, dqm, ba, addr, dq,
    output devDq, devDqOe);
  modport host (output cke, csN, rasN, casN, weN, dqm, ba, addr, hostDq, hostDqOe,
    input dq);
endinterface

`default_nettype wire

// file: core/sdci_device.sv
/*
  Memory device end: command decode, bank/row state, burst column
  generator, array storage, read pipeline and clock-gate power modes.
  Assumes every pin is synchronous to ref_clk and stands for one edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdci_cfg.svh"

module sdci_device #(
  parameter int ROW_BITS = `SDCI_ROW_BITS,
  parameter int COL_BITS = `SDCI_COL_BITS,
  parameter int DQ_BITS = `SDCI_DQ_BITS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sdci_if.dev pins,
  output logic [`SDCI_BANKS-1:0] bankOpen,
  output sdci_pkg::sdci_pwr_t pwrMode,
  output logic burstBusy
);
  import sdci_pkg::*;

  localparam int IDX_BITS = 2 + ROW_BITS + COL_BITS;
  localparam int MEM_WORDS = 1 << IDX_BITS;

  logic ckeQ;
  sdci_pwr_t pwrQ;
  logic [`SDCI_ADDR_BITS-1:0] modeQ;
  logic openQ [`SDCI_BANKS];
  logic [ROW_BITS-1:0] rowQ [`SDCI_BANKS];
  logic [`SDCI_BANKS-1:0] openVec;
  logic burstQ;
  logic burstWrQ;
  logic apQ;
  logic [1:0] bankQ;
  logic [COL_BITS-1:0] baseQ;
  logic [COL_BITS-1:0] cntQ;
  logic [DQ_BITS-1:0] mem [MEM_WORDS];
  logic pipe0VQ;
  logic pipe1VQ;
  logic [DQ_BITS-1:0] pipe0DQ;
  logic [DQ_BITS-1:0] pipe1DQ;
  logic dqmQ;
  logic oeQ;
  logic [DQ_BITS-1:0] outDQ;

  // Sleeping modes gate the whole input side off
  wire logic sleeping = (pwrQ == PWR_PDN_PRE) || (pwrQ == PWR_PDN_ACT) ||
    (pwrQ == PWR_SELF_REF);
  // An edge only counts when the clock gate was high one edge before
  wire logic go = ckeQ && !sleeping;
  wire logic cmdLive = go && !pins.csN;
  wire sdci_cmd_t cmd = sdci_cmd_t'({pins.rasN, pins.casN, pins.weN});
  wire logic apBit = pins.addr[`SDCI_AP_BIT];

  // Wide parts borrow the top address bit for the column
  wire logic [10:0] colWide = {pins.addr[11], pins.addr[9:0]};
  wire logic [COL_BITS-1:0] cmdCol = (COL_BITS == `SDCI_COL_BITS_X4) ?
    colWide[COL_BITS-1:0] : pins.addr[COL_BITS-1:0];

  // Accesses to a closed bank are dropped rather than corrupting a row
  wire logic isRw = cmdLive && (cmd == CMD_RD || cmd == CMD_WR);
  wire logic startRw = isRw && openVec[pins.ba];
  wire logic stopBurst = cmdLive && (cmd == CMD_BST ||
    (cmd == CMD_PRE && (apBit || pins.ba == bankQ)));
  wire logic allIdle = (openVec == '0) && !burstQ;

  wire logic [2:0] blCode = modeQ[`SDCI_BL_MSB:`SDCI_BL_LSB];
  wire logic fullPage = blCode == `SDCI_BL_PAGE;
  // Reserved length codes fall back to single beats
  wire logic [COL_BITS-1:0] lenM1 = fullPage ? {COL_BITS{1'b1}} :
    blCode[2] ? '0 : COL_BITS'((1 << blCode[1:0]) - 1);
  wire logic interleave = modeQ[`SDCI_BT_BIT] && !fullPage;
  wire logic [COL_BITS-1:0] seqCol = (baseQ & ~lenM1) | ((baseQ + cntQ) & lenM1);
  wire logic [COL_BITS-1:0] burstCol = interleave ? (baseQ ^ cntQ) : seqCol;
  wire logic clLong = modeQ[`SDCI_CL_MSB:`SDCI_CL_LSB] == `SDCI_CL_LONG;

  // A read or write to an open bank, a burst stop or a matching precharge preempts the running burst on the same edge
  wire logic advance = go && burstQ && !startRw && !stopBurst;
  wire logic accEn = startRw || advance;
  wire logic [1:0] accBank = startRw ? pins.ba : bankQ;
  wire logic [COL_BITS-1:0] accCol = startRw ? cmdCol : burstCol;
  wire logic accWr = startRw ? (cmd == CMD_WR) : burstWrQ;
  wire logic accAp = startRw ? apBit : apQ;
  wire logic [COL_BITS-1:0] beatNum = startRw ? '0 : cntQ;
  wire logic endNow = accEn && !fullPage && (beatNum == lenM1);
  wire logic [IDX_BITS-1:0] idx = {accBank, rowQ[accBank], accCol};

  wire sdci_pwr_t pwrEntry = (cmdLive && cmd == CMD_REF && allIdle) ? PWR_SELF_REF :
    burstQ ? PWR_SUSPEND : (openVec != '0) ? PWR_PDN_ACT : PWR_PDN_PRE;

  assign bankOpen = openVec;
  assign pwrMode = pwrQ;
  assign burstBusy = burstQ;
  assign pins.devDq = outDQ;
  assign pins.devDqOe = oeQ;

  // Row state per bank; banks act independently so precharge can hide
  for (genvar b = 0; b < `SDCI_BANKS; b++) begin : g_bank
    wire logic sel = pins.ba == 2'(b);
    wire logic act = cmdLive && cmd == CMD_ACT && sel && !openQ[b];
    wire logic pre = cmdLive && cmd == CMD_PRE && (apBit || sel);
    wire logic autoPre = endNow && accAp && accBank == 2'(b);
    assign openVec[b] = openQ[b];
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        openQ[b] <= 1'b0;
        rowQ[b] <= '0;
      end else if (act) begin
        openQ[b] <= 1'b1;
        rowQ[b] <= pins.addr[ROW_BITS-1:0];
      end else if (pre || autoPre) begin
        openQ[b] <= 1'b0;
      end
    end
  end

  // Mode changes are only taken with every bank idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      modeQ <= `SDCI_MODE_RST;
    end else if (cmdLive && cmd == CMD_LMR && allIdle) begin
      modeQ <= pins.addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      burstQ <= 1'b0;
      burstWrQ <= 1'b0;
      apQ <= 1'b0;
      bankQ <= '0;
      baseQ <= '0;
      cntQ <= '0;
    end else if (startRw) begin
      burstQ <= !endNow;
      burstWrQ <= accWr;
      apQ <= accAp;
      bankQ <= pins.ba;
      baseQ <= cmdCol;
      cntQ <= COL_BITS'(1);
    end else if (stopBurst) begin
      burstQ <= 1'b0;
    end else if (advance) begin
      burstQ <= !endNow;
      cntQ <= cntQ + COL_BITS'(1);
    end
  end

  // Write data rides with each beat; mask holds even when deselected
  always_ff @(posedge ref_clk) begin
    if (accEn && accWr && !pins.dqm) begin
      mem[idx] <= pins.dq;
    end
  end

  // Latency 2 reads from stage 0, latency 3 from stage 1
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pipe0VQ <= 1'b0;
      pipe1VQ <= 1'b0;
      pipe0DQ <= '0;
      pipe1DQ <= '0;
    end else if (go) begin
      pipe0VQ <= accEn && !accWr;
      pipe0DQ <= mem[idx];
      pipe1VQ <= pipe0VQ;
      pipe1DQ <= pipe0DQ;
    end
  end

  // Mask seen one edge late plus the output flop gives two clocks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dqmQ <= 1'b0;
      oeQ <= 1'b0;
      outDQ <= '0;
    end else if (go) begin
      dqmQ <= pins.dqm;
      oeQ <= (clLong ? pipe1VQ : pipe0VQ) && !dqmQ;
      outDQ <= clLong ? pipe1DQ : pipe0DQ;
    end
  end

  // Clock gate is watched every edge; sleeping leaves on its first high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ckeQ <= 1'b0;
      pwrQ <= PWR_RUN;
    end else begin
      ckeQ <= pins.cke;
      case (pwrQ)
        PWR_RUN: begin
          if (ckeQ && !pins.cke) begin
            pwrQ <= pwrEntry;
          end
        end
        default: begin
          if (pins.cke) begin
            pwrQ <= PWR_RUN;
          end
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// file: core/sdci_host.sv
/*
  Controller end: request FIFO and a one-access-at-a-time sequencer
  with periodic refresh and sleep control. Every access is a single
  beat with auto precharge. Assumes the device resets with it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdci_cfg.svh"

module sdci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SDCI_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrQ;
  logic [PW-1:0] rdQ;
  logic [PW:0] cntQ;

  wire logic push = inValid && inReady;
  wire logic pop = outValid && outReady;
  wire logic [PW:0] cntD = cntQ + (PW+1)'(push) - (PW+1)'(pop);

  assign outData = store[rdQ];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      store[wrQ] <= inData;
    end
  end

  // Flags are registered from the next count so they never lie
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrQ <= '0;
      rdQ <= '0;
      cntQ <= '0;
      inReady <= 1'b0;
      outValid <= 1'b0;
    end else begin
      wrQ <= wrQ + PW'(push);
      rdQ <= rdQ + PW'(pop);
      cntQ <= cntD;
      inReady <= cntD != (PW+1)'(DEPTH);
      outValid <= cntD != '0;
    end
  end
endmodule

module sdci_host #(
  parameter int ROW_BITS = `SDCI_ROW_BITS,
  parameter int COL_BITS = `SDCI_COL_BITS,
  parameter int DQ_BITS = `SDCI_DQ_BITS,
  parameter int REF_CYC = `SDCI_REF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sdci_if.host pins,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [1:0] reqBank,
  input wire logic [ROW_BITS-1:0] reqRow,
  input wire logic [COL_BITS-1:0] reqCol,
  input wire logic [DQ_BITS-1:0] reqData,
  output logic rdValid,
  output logic [DQ_BITS-1:0] rdData,
  input wire logic sleepReq,
  input wire logic extendedTempOption
);
  import sdci_pkg::*;

  localparam int FW = 1 + 2 + ROW_BITS + COL_BITS + DQ_BITS;
  localparam int RCW = $clog2(REF_CYC + 1);

  sdci_hst_t stQ;
  sdci_cmd_t cmdQ;
  logic [7:0] waitQ;
  logic csNQ;
  logic ckeQ;
  logic [1:0] baQ;
  logic [`SDCI_ADDR_BITS-1:0] addrQ;
  logic [DQ_BITS-1:0] dqQ;
  logic dqOeQ;
  logic rdPendQ;
  logic [RCW-1:0] refCntQ;
  logic refDueQ;
  logic fifoValid;
  logic [FW-1:0] fifoWord;

  wire logic wWr = fifoWord[FW-1];
  wire logic [1:0] wBank = fifoWord[FW-2 -: 2];
  wire logic [ROW_BITS-1:0] wRow = fifoWord[DQ_BITS+COL_BITS +: ROW_BITS];
  wire logic [10:0] wCol = 11'(fifoWord[DQ_BITS +: COL_BITS]);
  wire logic [DQ_BITS-1:0] wData = fifoWord[DQ_BITS-1:0];
  wire logic ready = waitQ == '0;
  // Head word stays queued until its access goes out
  wire logic fifoTake = stQ == H_RW && ready;
  wire logic issueRef = stQ == H_IDLE && ready && refDueQ;
  wire logic refTick = refCntQ == '0;
  wire logic [`SDCI_ADDR_BITS-1:0] colAddr =
    {(COL_BITS == `SDCI_COL_BITS_X4) ? wCol[10] : 1'b0, 1'b1, wCol[9:0]};

  assign pins.cke = ckeQ;
  assign pins.csN = csNQ;
  assign {pins.rasN, pins.casN, pins.weN} = cmdQ;
  assign pins.dqm = 1'b0;
  assign pins.ba = baQ;
  assign pins.addr = addrQ;
  assign pins.hostDq = dqQ;
  assign pins.hostDqOe = dqOeQ;

  sdci_fifo #(.WIDTH(FW), .DEPTH(`SDCI_FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inValid(reqValid),
    .inData({reqWrite, reqBank, reqRow, reqCol, reqData}),
    .inReady(reqReady),
    .outValid(fifoValid),
    .outData(fifoWord),
    .outReady(fifoTake)
  );

  // One row every period share; a tick that meets an issue stays pending
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      refCntQ <= RCW'(REF_CYC);
      refDueQ <= 1'b0;
    end else begin
      refCntQ <= refTick ? RCW'(REF_CYC) : refCntQ - RCW'(1);
      refDueQ <= refTick || (refDueQ && !issueRef);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stQ <= H_PRE;
      cmdQ <= CMD_NOP;
      csNQ <= 1'b1;
      ckeQ <= 1'b1;
      baQ <= '0;
      addrQ <= '0;
      dqQ <= '0;
      dqOeQ <= 1'b0;
      waitQ <= `SDCI_GAP_CYC;
      rdPendQ <= 1'b0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else begin
      cmdQ <= CMD_NOP;
      csNQ <= 1'b1;
      dqOeQ <= 1'b0;
      rdValid <= 1'b0;
      if (!ready) begin
        waitQ <= waitQ - 8'h01;
      end
      case (stQ)
        H_PRE: begin
          if (ready) begin
            cmdQ <= CMD_PRE;
            csNQ <= 1'b0;
            addrQ <= 12'h400;
            waitQ <= `SDCI_GAP_CYC;
            stQ <= H_LMR;
          end
        end
        H_LMR: begin
          if (ready) begin
            cmdQ <= CMD_LMR;
            csNQ <= 1'b0;
            addrQ <= `SDCI_MODE_RST;
            waitQ <= `SDCI_GAP_CYC;
            stQ <= H_IDLE;
          end
        end
        H_IDLE: begin
          if (ready && refDueQ) begin
            cmdQ <= CMD_REF;
            csNQ <= 1'b0;
            waitQ <= `SDCI_GAP_CYC;
          end else if (ready && sleepReq) begin
            ckeQ <= 1'b0;
            // Hot parts may not self refresh, so they only power down
            cmdQ <= extendedTempOption ? CMD_NOP : CMD_REF;
            csNQ <= extendedTempOption;
            stQ <= H_SLEEP;
          end else if (ready && fifoValid) begin
            cmdQ <= CMD_ACT;
            csNQ <= 1'b0;
            baQ <= wBank;
            addrQ <= 12'(wRow);
            waitQ <= `SDCI_GAP_CYC;
            stQ <= H_RW;
          end
        end
        H_RW: begin
          if (ready) begin
            cmdQ <= wWr ? CMD_WR : CMD_RD;
            csNQ <= 1'b0;
            addrQ <= colAddr;
            dqQ <= wData;
            dqOeQ <= wWr;
            rdPendQ <= !wWr;
            waitQ <= wWr ? `SDCI_GAP_CYC : `SDCI_HOST_CL;
            stQ <= H_DATA;
          end
        end
        H_DATA: begin
          if (ready) begin
            rdValid <= rdPendQ;
            rdData <= rdPendQ ? pins.dq : rdData;
            waitQ <= `SDCI_GAP_CYC;
            stQ <= H_IDLE;
          end
        end
        H_SLEEP: begin
          // Power-down cannot refresh by itself, so a due tick wakes it
          if (!sleepReq || (extendedTempOption && refDueQ)) begin
            ckeQ <= 1'b1;
            waitQ <= `SDCI_GAP_CYC;
            stQ <= H_IDLE;
          end
        end
        default: begin
          stQ <= H_IDLE;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// file: testbench/sdci_pins_asserts.sv
/* Assertions on the controller-to-device pins of one bundle.
   Assumes the bench instances it beside the bundle, clocked by ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module sdci_pins_asserts #(
  parameter int REF_CYC = 78
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [1:0] ba,
  input wire logic [11:0] addr,
  input wire logic hostDqOe,
  input wire logic devDqOe
);
  logic [2:0] cmd;
  logic rd, wr, act;
  logic [3:0] openQ;
  int refCnt;
  assign cmd = csN ? 3'h7 : {rasN, casN, weN};
  assign rd = cmd == 3'h5;
  assign wr = cmd == 3'h4;
  assign act = cmd == 3'h3;
  // Row state rebuilt from the commands alone
  always_ff @(posedge ref_clk) begin
    if (!rst_n) openQ <= 4'h0;
    else if (act) openQ[ba] <= 1'b1;
    else if ((rd || wr) && addr[10]) openQ[ba] <= 1'b0;
    else if (cmd == 3'h2) openQ <= addr[10] ? 4'h0 : openQ & ~(4'h1 << ba);
  end
  // Gated clock restarts the count, no refresh owed meanwhile
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !cke || cmd == 3'h1) refCnt <= 0;
    else refCnt <= refCnt + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_idle2; (cmd == 3'h7) [*2]; endsequence
  sequence s_wr_beat; hostDqOe ##1 !hostDqOe; endsequence
  property p_rd_answer; rd |-> ##2 devDqOe; endproperty
  property p_rd_cause; $rose(devDqOe) |-> $past(rd, 2); endproperty
  property p_one_beat; devDqOe |=> !devDqOe; endproperty
  property p_act_first; (rd || wr) |-> openQ[ba]; endproperty
  property p_auto_pre; (rd || wr) |-> addr[10]; endproperty
  property p_wr_data; wr |-> s_wr_beat; endproperty
  property p_no_stray; hostDqOe |-> wr; endproperty
  property p_gap; cmd != 3'h7 |=> s_idle2; endproperty
  property p_refresh; refCnt < REF_CYC + 40; endproperty
  property p_sleep_idle; $fell(cke) |-> openQ == 4'h0; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  a_rd_cause: assert property (p_rd_cause) else $error("data without read");
  a_one_beat: assert property (p_one_beat) else $error("read beat too long");
  a_act_first: assert property (p_act_first) else $error("access to closed bank");
  a_auto_pre: assert property (p_auto_pre) else $error("access without autoclose");
  a_wr_data: assert property (p_wr_data) else $error("write data not with command");
  a_no_stray: assert property (p_no_stray) else $error("data driven without write");
  a_gap: assert property (p_gap) else $error("commands too close");
  a_refresh: assert property (p_refresh) else $error("refresh overdue");
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep with open row");
endmodule
`default_nettype wire

// file: testbench/sdram_command_interface_bench.sv
/* Bench: controller and device joined by one bundle; a second device
   driven by hand. Assumes core/ is on the include path. */
`timescale 1ns/1ps
`default_nettype none
module sdram_command_interface_bench;
  import sdci_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [1:0] reqBank = 2'h0;
  logic [11:0] reqRow = 12'h000;
  logic [8:0] reqCol = 9'h000;
  logic [15:0] reqData = 16'h0000;
  logic sleepReq = 1'b0;
  logic extendedTempOption = 1'b0;
  logic reqReady, rdValid, stalled;
  logic ckeSeen, busy1;
  logic [15:0] rdData;
  logic [3:0] open0, open1;
  sdci_pwr_t pwr0, pwr1;
  int numErrors = 0;
  int nCompared = 0;
  int k;
  logic [15:0] got[$];
  logic [10:0] want[$];
  logic [15:0] mem[logic [10:0]];
  sdci_if if0();
  sdci_if if1();
  always #25 ref_clk = ~ref_clk;
  sdci_host #(.REF_CYC(20)) sdci_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .pins(if0),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqBank(reqBank),
    .reqRow(reqRow), .reqCol(reqCol), .reqData(reqData), .rdValid(rdValid),
    .rdData(rdData), .sleepReq(sleepReq), .extendedTempOption(extendedTempOption));
  sdci_device #(.ROW_BITS(4)) sdci_device_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .pins(if0), .bankOpen(open0), .pwrMode(pwr0), .burstBusy());
  sdci_device #(.ROW_BITS(4)) sdci_device_inst2 (.ref_clk(ref_clk), .rst_n(rst_n),
    .pins(if1), .bankOpen(open1), .pwrMode(pwr1), .burstBusy(busy1));
  sdci_pins_asserts #(.REF_CYC(20)) sdci_pins_asserts_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .cke(if0.cke), .csN(if0.csN), .rasN(if0.rasN), .casN(if0.casN),
    .weN(if0.weN), .ba(if0.ba), .addr(if0.addr), .hostDqOe(if0.hostDqOe),
    .devDqOe(if0.devDqOe));
  always @(negedge ref_clk) begin
    if (rdValid === 1'b1) got.push_back(rdData);
  end
  task automatic summarize();
    $display("compared %0d, mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask
  // Row follows the bank so each bank uses its own row
  task automatic push(input logic w, input logic [1:0] b, input logic [8:0] c,
                      input logic [15:0] d);
    int n;
    reqValid = 1'b1;
    reqWrite = w;
    reqBank = b;
    reqRow = 12'(b) + 12'h005;
    reqCol = c;
    reqData = d;
    if (w) mem[{b, c}] = d;
    else want.push_back({b, c});
    for (n = 0; n < 400 && reqReady !== 1'b1; n++) @(negedge ref_clk);
    if (n > 0) stalled = 1'b1;
    if (n == 400) begin
      numErrors++;
      summarize();
    end
    @(negedge ref_clk);
  endtask
  task automatic drain();
    int n;
    reqValid = 1'b0;
    for (n = 0; n < 3000 && got.size() < want.size(); n++) @(negedge ref_clk);
    if (n == 3000) begin
      numErrors++;
      summarize();
    end
    foreach (want[i]) chk(got[i], mem[want[i]]);
    got.delete();
    want.delete();
  endtask
  task automatic cmd(input logic cs, input sdci_cmd_t c, input logic [1:0] b,
                     input logic [11:0] a, input logic [15:0] d);
    if1.csN = cs;
    {if1.rasN, if1.casN, if1.weN} = c;
    if1.ba = b;
    if1.addr = a;
    if1.hostDq = d;
    @(negedge ref_clk);
  endtask
  // Beats are watched with the device deselected: bursts must carry on
  task automatic rdChk(input int cl, input logic [63:0] e, input logic [3:0] m);
    int j;
    for (int i = 1; i <= cl + 2; i++) begin
      j = i - cl + 2;
      if1.dqm = (j < 4) ? m[j] : 1'b0;
      cmd(1'b1, CMD_NOP, 2'h0, 12'h000, 16'h0);
      j = i + 1 - cl;
      if (j >= 0) begin
        chk(16'(if1.devDqOe), 16'(!m[j]));
        if (!m[j]) chk(if1.dq, e[63 - 16 * j -: 16]);
      end
    end
  endtask
  initial begin
    if1.cke = 1'b1;
    if1.dqm = 1'b0;
    if1.hostDqOe = 1'b0;
    cmd(1'b1, CMD_NOP, 2'h0, 12'h000, 16'h0);
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    for (int b = 0; b < 4; b++) push(1'b1, 2'(b), 9'(b * 170), 16'ha100 + 16'(b));
    for (int b = 0; b < 4; b++) push(1'b0, 2'(b), 9'(b * 170), 16'h0);
    drain();
    chk(16'(open0), 16'h0);
    $display("test 1 done");
    stalled = 1'b0;
    for (int i = 0; i < 24; i++) push(1'b1, 2'h2, 9'(i), 16'h5a00 + 16'(i));
    for (int i = 0; i < 24; i++) push(1'b0, 2'h2, 9'(i), 16'h0);
    drain();
    chk(16'(stalled), 16'h1);
    $display("test 2 done");
    for (int t = 0; t < 2; t++) begin
      extendedTempOption = t[0];
      sleepReq = 1'b1;
      // Gate level the entry edge saw; a due refresh may wake the host next edge
      for (k = 0; k < 300 && pwr0 === PWR_RUN; k++) begin
        ckeSeen = if0.cke;
        @(negedge ref_clk);
      end
      if (k == 300) begin
        numErrors++;
        summarize();
      end
      chk(16'(pwr0), t ? 16'(PWR_PDN_PRE) : 16'(PWR_SELF_REF));
      chk(16'(ckeSeen), 16'h0);
      sleepReq = 1'b0;
      for (k = 0; k < 300 && pwr0 !== PWR_RUN; k++) @(negedge ref_clk);
      if (k == 300) begin
        numErrors++;
        summarize();
      end
      push(1'b0, 2'h1, 9'd170, 16'h0);
      drain();
    end
    $display("test 3 done");
    cmd(1'b1, CMD_ACT, 2'h1, 12'h003, 16'h0);
    cmd(1'b0, CMD_NOP, 2'h0, 12'h000, 16'h0);
    chk(16'(open1), 16'h0);
    cmd(1'b0, CMD_RD, 2'h2, 12'h000, 16'h0);
    rdChk(2, 64'h0, 4'hf);
    cmd(1'b0, CMD_LMR, 2'h0, 12'h022, 16'h0);
    cmd(1'b0, CMD_ACT, 2'h1, 12'h003, 16'h0);
    if1.hostDqOe = 1'b1;
    for (int i = 0; i < 4; i++) cmd(1'b0, i == 0 ? CMD_WR : CMD_NOP, 2'h1, 12'h002, 16'h00c0 + 16'(i));
    if1.hostDqOe = 1'b0;
    chk(16'(open1), 16'h2);
    cmd(1'b0, CMD_RD, 2'h1, 12'h000, 16'h0);
    rdChk(2, 64'h00c2_00c3_00c0_00c1, 4'h2);
    cmd(1'b0, CMD_ACT, 2'h3, 12'h004, 16'h0);
    cmd(1'b0, CMD_PRE, 2'h3, 12'h000, 16'h0);
    cmd(1'b0, CMD_NOP, 2'h0, 12'h000, 16'h0);
    chk(16'(open1), 16'h2);
    cmd(1'b0, CMD_PRE, 2'h0, 12'h400, 16'h0);
    cmd(1'b0, CMD_NOP, 2'h0, 12'h000, 16'h0);
    chk(16'(open1), 16'h0);
    cmd(1'b0, CMD_LMR, 2'h0, 12'h03a, 16'h0);
    cmd(1'b0, CMD_ACT, 2'h1, 12'h003, 16'h0);
    cmd(1'b0, CMD_RD, 2'h1, 12'h401, 16'h0);
    rdChk(3, 64'h00c3_00c2_00c1_00c0, 4'h0);
    chk(16'(open1), 16'h0);
    // Gate dropped with a row open, then raised; then a burst cut short
    cmd(1'b0, CMD_ACT, 2'h0, 12'h001, 16'h0);
    if1.cke = 1'b0;
    cmd(1'b1, CMD_NOP, 2'h0, 12'h000, 16'h0);
    chk(16'(pwr1), 16'(PWR_PDN_ACT));
    if1.cke = 1'b1;
    cmd(1'b1, CMD_NOP, 2'h0, 12'h000, 16'h0);
    chk(16'(pwr1), 16'(PWR_RUN));
    cmd(1'b0, CMD_RD, 2'h0, 12'h000, 16'h0);
    chk(16'(busy1), 16'h1);
    cmd(1'b0, CMD_BST, 2'h0, 12'h000, 16'h0);
    chk(16'(busy1), 16'h0);
    $display("test 4 done");
    summarize();
  end
endmodule
`default_nettype wire
